/* src/cte_event_ctrl.sv */
// Current threshold event configuration, detection and interrupt output.
// Assumes SPI pins and samples are synchronous to mclk, sck well below mclk/4.
// Behaviour
// - Threshold 2 is a 15-bit magnitude plus direction in high byte bit 7.
// - Threshold 3 uses the same magnitude and direction layout.
// - Relax time code selects 30, 60, 90 or 120 minutes.
// - Threshold repeat codes select 1, 4, 8 or 16 detections.
// - Threshold events need the selected number of consecutive detections.
// - Relax timer runs only while current is at or below level, unsigned.
// - Wake repeat code selects 1, 4, 8 or 16 consecutive detections.
// - Start-up wait selects 1.5, 3, 6 or 12 milliseconds.
// - Enabled set flag pulls interrupt low; disabled never pulls it.
// - First enable register holds charge/discharge pairs for four monitors.
// - Enabled threshold events for above in the selected direction or otherwise, held for the count.
// - Wake flag when magnitude exceeds zero-extended level for the count.
// - Relax flag once at or below relax level for the chosen time.
`timescale 1ns/1ps
module cte_event_ctrl
  import cte_pkg::*;
#(
  parameter longint STARTUP_BASE = STARTUP_BASE_CYCLES,
  parameter longint MINUTE_LEN   = MINUTE_CYCLES
)(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // SPI slave.
  input  wire logic        spi_sck,
  input  wire logic        spi_csb_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  // Measured current and accumulation monitor events.
  input  wire cte_sample_s sample,
  input  wire logic        sample_valid,
  input  wire logic [7:0]  monitor_event,
  input  wire logic        amp_start,
  // Open-drain interrupt and status.
  output logic             interrupt_out_n,
  output logic             interrupt_oe_n,
  output logic             analog_ready
);

  // The wait counters are 32 bits wide, so longer time bases cannot be served.
  if (STARTUP_BASE < 1 || STARTUP_BASE > 64'h0FFF_FFFF || MINUTE_LEN < 1
      || MINUTE_LEN > 64'h7FFF_FFFF) begin : g_bad_timing
    $error("cte_event_ctrl: unsupported timing parameter");
  end

  // Configuration registers.
  logic [7:0] lim2_hi_r, lim2_lo_r, lim3_hi_r, lim3_lo_r;
  logic [7:0] timing_r, relax_lvl_r, wake_lvl_r, startup_r;
  logic [7:0] irq_en1_r, irq_en2_r, irq_en3_r;
  logic [7:0] flag1_r, flag2_r, flag3_r;

  // SPI: 16-bit frame, first byte {write, addr[6:0]}, second byte data, MSB first.
  logic       sck_q_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic [7:0] cmd_r, rd_shift_r, rd_mux;
  logic       sck_rise, sck_fall, wr_stb;
  logic [7:0] wr_data;

  assign sck_rise = spi_sck && !sck_q_r && !spi_csb_n;
  assign sck_fall = !spi_sck && sck_q_r && !spi_csb_n;
  assign wr_data  = {shift_r, spi_sdi};
  assign wr_stb   = sck_rise && (bit_cnt_r == 4'hF) && cmd_r[7];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q_r    <= 1'b0;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 7'h00;
      cmd_r      <= 8'h00;
      rd_shift_r <= 8'h00;
      spi_sdo    <= 1'b0;
    end else begin
      sck_q_r <= spi_sck;
      if (spi_csb_n) begin
        bit_cnt_r <= 4'h0;
        spi_sdo   <= 1'b0;
      end else if (sck_rise) begin
        shift_r   <= wr_data[6:0];
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == 4'h7) begin
          cmd_r      <= wr_data;
          rd_shift_r <= rd_mux;
        end
      end else if (sck_fall && bit_cnt_r[3]) begin
        spi_sdo    <= rd_shift_r[7];
        rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      end
    end
  end

  // Read data for the address just received; unmapped addresses read 00h.
  always_comb begin
    unique case (wr_data[6:0])
      ADDR_LIM2_HI:    rd_mux = lim2_hi_r;
      ADDR_LIM2_LO:    rd_mux = lim2_lo_r;
      ADDR_LIM3_HI:    rd_mux = lim3_hi_r;
      ADDR_LIM3_LO:    rd_mux = lim3_lo_r;
      ADDR_DET_TIMING: rd_mux = timing_r;
      ADDR_RELAX_LVL:  rd_mux = relax_lvl_r;
      ADDR_WAKE_LVL:   rd_mux = wake_lvl_r;
      ADDR_STARTUP:    rd_mux = startup_r;
      ADDR_IRQ_EN1:    rd_mux = irq_en1_r;
      ADDR_IRQ_EN2:    rd_mux = irq_en2_r;
      ADDR_IRQ_EN3:    rd_mux = irq_en3_r;
      ADDR_FLAG1:      rd_mux = flag1_r;
      ADDR_FLAG2:      rd_mux = flag2_r;
      ADDR_FLAG3:      rd_mux = flag3_r;
      default:         rd_mux = 8'h00;
    endcase
  end

  // Plain read/write configuration; reserved bits of the start-up register stay zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lim2_hi_r   <= REG_RESET;
      lim2_lo_r   <= REG_RESET;
      lim3_hi_r   <= REG_RESET;
      lim3_lo_r   <= REG_RESET;
      timing_r    <= REG_RESET;
      relax_lvl_r <= REG_RESET;
      wake_lvl_r  <= REG_RESET;
      startup_r   <= REG_RESET;
      irq_en1_r   <= REG_RESET;
      irq_en2_r   <= REG_RESET;
      irq_en3_r   <= REG_RESET;
    end else if (wr_stb) begin
      unique case (cmd_r[6:0])
        ADDR_LIM2_HI:    lim2_hi_r   <= wr_data;
        ADDR_LIM2_LO:    lim2_lo_r   <= wr_data;
        ADDR_LIM3_HI:    lim3_hi_r   <= wr_data;
        ADDR_LIM3_LO:    lim3_lo_r   <= wr_data;
        ADDR_DET_TIMING: timing_r    <= wr_data;
        ADDR_RELAX_LVL:  relax_lvl_r <= wr_data;
        ADDR_WAKE_LVL:   wake_lvl_r  <= wr_data;
        ADDR_STARTUP:    startup_r   <= wr_data & 8'h33;
        ADDR_IRQ_EN1:    irq_en1_r   <= wr_data;
        ADDR_IRQ_EN2:    irq_en2_r   <= wr_data & EN2_MASK;
        ADDR_IRQ_EN3:    irq_en3_r   <= wr_data & EN3_MASK;
        default:         ;
      endcase
    end
  end

  // Start-up wait; detection stays idle until the analog front end settles.
  logic [31:0] settle_cnt_r, settle_target;
  logic        ready_r;
  assign settle_target = 32'(STARTUP_BASE << startup_r[SETTLE_LSB +: 2]);
  assign analog_ready  = ready_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_r <= 32'h0000_0000;
      ready_r      <= 1'b0;
    end else if (amp_start) begin
      settle_cnt_r <= 32'h0000_0000;
      ready_r      <= 1'b0;
    end else if (!ready_r) begin
      settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
      ready_r      <= (settle_cnt_r + 32'h0000_0001 >= settle_target);
    end
  end

  // Detection conditions.
  logic       take;
  logic [5:0] cond, hit;
  logic [1:0] sel [6];
  assign take = sample_valid && ready_r;
  // Above the threshold in the selected direction is a detect, otherwise a release.
  assign cond[0] = sample.discharge == lim2_hi_r[DIR_BIT]
                   && sample.magnitude > {lim2_hi_r[6:0], lim2_lo_r};
  assign cond[1] = !cond[0];
  assign cond[2] = sample.discharge == lim3_hi_r[DIR_BIT]
                   && sample.magnitude > {lim3_hi_r[6:0], lim3_lo_r};
  assign cond[3] = !cond[2];
  assign cond[4] = sample.magnitude > {7'h00, wake_lvl_r};
  assign cond[5] = !cond[4];
  assign sel[0]  = timing_r[LIM2_CNT_LSB +: 2];
  assign sel[1]  = timing_r[LIM2_CNT_LSB +: 2];
  assign sel[2]  = timing_r[LIM3_CNT_LSB +: 2];
  assign sel[3]  = timing_r[LIM3_CNT_LSB +: 2];
  assign sel[4]  = startup_r[WAKE_CNT_LSB +: 2];
  assign sel[5]  = startup_r[WAKE_CNT_LSB +: 2];

  for (genvar g = 0; g < 6; g++) begin : g_repeat
    cte_repeat_count u_repeat (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .sample_valid (take),
      .cond         (cond[g]),
      .count_sel    (sel[g]),
      .hit          (hit[g])
    );
  end

  // Relaxation timer, counted in minutes.
  logic [31:0] minute_cnt_r;
  logic [6:0]  relax_min_r, relax_target;
  logic        low_r, minute_tick, relax_hit;
  assign relax_target = 7'(RELAX_STEP_MIN) * {5'h00, timing_r[RELAX_SEL_LSB +: 2]}
                        + 7'(RELAX_STEP_MIN);
  assign minute_tick  = low_r && (minute_cnt_r == 32'(MINUTE_LEN - 1));
  assign relax_hit    = minute_tick && (relax_min_r + 7'h01 == relax_target);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_r        <= 1'b0;
      minute_cnt_r <= 32'h0000_0000;
      relax_min_r  <= 7'h00;
    end else begin
      if (take) begin
        low_r <= sample.magnitude <= {7'h00, relax_lvl_r};
      end
      if (!low_r || !ready_r) begin
        minute_cnt_r <= 32'h0000_0000;
        relax_min_r  <= 7'h00;
      end else if (minute_tick) begin
        minute_cnt_r <= 32'h0000_0000;
        if (relax_min_r < relax_target) begin
          relax_min_r <= relax_min_r + 7'h01;
        end
      end else begin
        minute_cnt_r <= minute_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Sticky flags: write 1 clears, and a new event in the same cycle wins.
  logic [7:0] clr1, clr2, clr3, set2, set3;
  assign clr1 = (wr_stb && cmd_r[6:0] == ADDR_FLAG1) ? wr_data : 8'h00;
  assign clr2 = (wr_stb && cmd_r[6:0] == ADDR_FLAG2) ? wr_data : 8'h00;
  assign clr3 = (wr_stb && cmd_r[6:0] == ADDR_FLAG3) ? wr_data : 8'h00;
  assign set2 = {hit[3], hit[2], hit[1], hit[0], 4'h0} & irq_en2_r;
  assign set3 = {5'h00, relax_hit, hit[5], hit[4]};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag1_r <= REG_RESET;
      flag2_r <= REG_RESET;
      flag3_r <= REG_RESET;
    end else begin
      flag1_r <= (flag1_r & ~clr1) | monitor_event;
      flag2_r <= (flag2_r & ~clr2) | set2;
      flag3_r <= (flag3_r & ~clr3) | set3;
    end
  end

  // Interrupt pin: output value is always low, the enable decides pull or release.
  logic pull_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pull_r <= 1'b0;
    end else begin
      pull_r <= |(flag1_r & irq_en1_r) || |(flag2_r & irq_en2_r)
                || |(flag3_r & irq_en3_r);
    end
  end
  assign interrupt_out_n = 1'b0;
  assign interrupt_oe_n  = !pull_r;

  // Checks.
  property p_irq_pull;
    @(posedge mclk) disable iff (!reset_n)
      |(flag1_r & irq_en1_r) |=> !interrupt_oe_n;
  endproperty
  a_irq_pull: assert property (p_irq_pull) else $error("enabled flag not on pin");

  property p_irq_release;
    @(posedge mclk) disable iff (!reset_n)
      (flag1_r & irq_en1_r) == 8'h00 && (flag2_r & irq_en2_r) == 8'h00
      && (flag3_r & irq_en3_r) == 8'h00 |=> interrupt_oe_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("pin pulled without cause");

  property p_lim2_det;
    @(posedge mclk) disable iff (!reset_n)
      $rose(flag2_r[F2_LIM2_DET]) |-> $past(take && cond[0] && irq_en2_r[F2_LIM2_DET]);
  endproperty
  a_lim2_det: assert property (p_lim2_det) else $error("limit2 detect without cause");

  property p_lim2_four;
    @(posedge mclk) disable iff (!reset_n)
      $rose(flag2_r[F2_LIM2_DET]) && timing_r[LIM2_CNT_LSB +: 2] == 2'b01
      |-> g_repeat[0].u_repeat.streak_r == 5'h04;
  endproperty
  a_lim2_four: assert property (p_lim2_four) else $error("limit2 count not four");

  property p_wake;
    @(posedge mclk) disable iff (!reset_n)
      $rose(flag3_r[F3_WAKE_DET]) |-> $past(sample.magnitude > {7'h00, wake_lvl_r});
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag without over-current");

  property p_relax;
    @(posedge mclk) disable iff (!reset_n)
      $rose(flag3_r[F3_RELAX]) |-> relax_min_r == relax_target && $past(low_r);
  endproperty
  a_relax: assert property (p_relax) else $error("relax flag early");

  property p_relax_hold;
    @(posedge mclk) disable iff (!reset_n)
      !low_r |=> minute_cnt_r == 32'h0000_0000;
  endproperty
  a_relax_hold: assert property (p_relax_hold) else $error("relax timer ran high");

  property p_settle;
    @(posedge mclk) disable iff (!reset_n)
      $rose(ready_r) |-> settle_cnt_r >= settle_target;
  endproperty
  a_settle: assert property (p_settle) else $error("ready before wait");

  property p_limit_store;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && cmd_r[6:0] == ADDR_LIM3_HI |=> lim3_hi_r == $past(wr_data);
  endproperty
  a_limit_store: assert property (p_limit_store) else $error("limit3 high not stored");

  c_lim2: cover property (@(posedge mclk) disable iff (!reset_n) $rose(flag2_r[F2_LIM2_DET]));
  c_wake: cover property (@(posedge mclk) disable iff (!reset_n) $rose(flag3_r[F3_WAKE_DET]));
  c_irq:  cover property (@(posedge mclk) disable iff (!reset_n) $fell(interrupt_oe_n));
  c_read: cover property (@(posedge mclk) disable iff (!reset_n)
                          sck_rise && bit_cnt_r == 4'h7 && !wr_data[7]);

endmodule : cte_event_ctrl

/* src/cte_pkg.sv */
// Constants and types for the current threshold event block.
// Assumes a 20 MHz mclk and a host that reaches the registers over SPI.
package cte_pkg;

  // Clock and time bases.
  localparam longint MCLK_HZ             = 20_000_000;
  localparam longint STARTUP_BASE_US     = 1500;
  localparam longint STARTUP_BASE_CYCLES = (STARTUP_BASE_US * MCLK_HZ) / 1_000_000;
  localparam longint MINUTE_S            = 60;
  localparam longint MINUTE_CYCLES       = MINUTE_S * MCLK_HZ;
  localparam int     RELAX_STEP_MIN      = 30;

  // Register addresses.
  localparam logic [6:0] ADDR_LIM2_HI    = 7'h31;
  localparam logic [6:0] ADDR_LIM2_LO    = 7'h32;
  localparam logic [6:0] ADDR_LIM3_HI    = 7'h33;
  localparam logic [6:0] ADDR_LIM3_LO    = 7'h34;
  localparam logic [6:0] ADDR_DET_TIMING = 7'h35;
  localparam logic [6:0] ADDR_RELAX_LVL  = 7'h36;
  localparam logic [6:0] ADDR_WAKE_LVL   = 7'h37;
  localparam logic [6:0] ADDR_STARTUP    = 7'h38;
  localparam logic [6:0] ADDR_IRQ_EN1    = 7'h39;
  localparam logic [6:0] ADDR_IRQ_EN2    = 7'h3A;
  localparam logic [6:0] ADDR_IRQ_EN3    = 7'h3B;
  localparam logic [6:0] ADDR_FLAG1      = 7'h3C;
  localparam logic [6:0] ADDR_FLAG2      = 7'h3D;
  localparam logic [6:0] ADDR_FLAG3      = 7'h3E;

  // Reset values.
  localparam logic [7:0] REG_RESET       = 8'h00;

  // Field positions.
  localparam int DIR_BIT        = 7;
  localparam int RELAX_SEL_LSB  = 6;
  localparam int LIM3_CNT_LSB   = 4;
  localparam int LIM2_CNT_LSB   = 2;
  localparam int SETTLE_LSB     = 4;
  localparam int WAKE_CNT_LSB   = 0;
  localparam int F2_LIM2_DET    = 4;
  localparam int F2_LIM2_REL    = 5;
  localparam int F2_LIM3_DET    = 6;
  localparam int F2_LIM3_REL    = 7;
  localparam int F3_WAKE_DET    = 0;
  localparam int F3_WAKE_REL    = 1;
  localparam int F3_RELAX       = 2;
  localparam logic [7:0] EN2_MASK = 8'hF0;
  localparam logic [7:0] EN3_MASK = 8'h07;

  // Consecutive-detection counts for codes 00, 01, 10, 11.
  localparam logic [4:0] REPEAT_C0 = 5'h01;
  localparam logic [4:0] REPEAT_C1 = 5'h04;
  localparam logic [4:0] REPEAT_C2 = 5'h08;
  localparam logic [4:0] REPEAT_C3 = 5'h10;

  // One measured-current sample: direction and magnitude.
  typedef struct packed {
    logic        discharge;
    logic [14:0] magnitude;
  } cte_sample_s;

endpackage : cte_pkg

/* src/cte_repeat_count.sv */
// Consecutive-detection counter: pulses once when a condition has held
// on the selected number of back-to-back samples.
// Assumes samples arrive as single-cycle valid strobes.
`timescale 1ns/1ps
module cte_repeat_count
  import cte_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Sample stream.
  input  wire logic       sample_valid,
  input  wire logic       cond,
  input  wire logic [1:0] count_sel,
  // Result.
  output logic            hit
);

  logic [4:0] streak_r;
  logic [4:0] need;

  always_comb begin
    unique case (count_sel)
      2'b00: need = REPEAT_C0;
      2'b01: need = REPEAT_C1;
      2'b10: need = REPEAT_C2;
      2'b11: need = REPEAT_C3;
    endcase
  end

  // The streak saturates so a long condition fires only once.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      streak_r <= 5'h00;
    end else if (sample_valid) begin
      if (!cond) begin
        streak_r <= 5'h00;
      end else if (streak_r < need) begin
        streak_r <= streak_r + 5'h01;
      end
    end
  end

  assign hit = sample_valid && cond && (streak_r == need - 5'h01);

endmodule : cte_repeat_count

/* verif/cte_spi_host.sv */
// SPI host model: whole 16-bit frames, MSB first, clock idle low.
// Assumes it shares mclk with the block; each clock phase lasts three mclk cycles.
`timescale 1ns/1ps
module cte_spi_host (
  // Clock.
  input  wire logic mclk,
  // SPI pins.
  output logic      spi_sck,
  output logic      spi_csb_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_sck   = 1'b0;
    spi_csb_n = 1'b1;
    spi_sdi   = 1'b1;
  end

  // Read data is taken at the rising clock edges of the data byte.
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rdata);
    rdata = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      @(posedge mclk) begin
        spi_csb_n <= 1'b0;
        spi_sck   <= 1'b0;
        spi_sdi   <= frame[i];
      end
      repeat (2) @(posedge mclk);
      @(posedge mclk) spi_sck <= 1'b1;
      if (i < 8) rdata[i] = spi_sdo;
      repeat (2) @(posedge mclk);
    end
    // The data line is toggled so that a stale bit never looks like a driven one.
    @(posedge mclk) begin
      spi_sck <= 1'b0;
      spi_sdi <= ~spi_sdi;
    end
    repeat (2) @(posedge mclk);
    @(posedge mclk) spi_csb_n <= 1'b1;
    @(posedge mclk);
  endtask : xfer

endmodule : cte_spi_host

/* verif/current_threshold_event_config_tb_top.sv */
// Self-checking bench for the current threshold event block.
// Assumes the package, the design and the SPI host model are compiled first.
`timescale 1ns/1ps
module current_threshold_event_config_tb_top
  import cte_pkg::*;
;
  // Short time bases keep the start-up and relaxation waits brief.
  localparam int BASE = 10;
  localparam int MIN  = 5;

  logic        mclk          = 1'b0;
  logic        reset_n       = 1'b0;
  logic        spi_sck;
  logic        spi_csb_n;
  logic        spi_sdi;
  logic        spi_sdo;
  cte_sample_s sample        = '0;
  logic        sample_valid  = 1'b0;
  logic [7:0]  monitor_event = 8'h00;
  logic        amp_start     = 1'b0;
  logic        int_out_n;
  logic        int_oe_n;
  logic        ready;
  logic [7:0]  rd_data;
  int          n_mismatch    = 0;
  int          checks_done   = 0;
  int          cycles        = 0;
  // The pin has a pull-up, so a released pin reads high.
  wire         int_pin       = int_oe_n ? 1'b1 : int_out_n;

  always #25 mclk = ~mclk;

  cte_event_ctrl #(.STARTUP_BASE(BASE), .MINUTE_LEN(MIN)) DUT (
    .mclk(mclk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_csb_n(spi_csb_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .sample(sample), .sample_valid(sample_valid),
    .monitor_event(monitor_event), .amp_start(amp_start), .interrupt_out_n(int_out_n),
    .interrupt_oe_n(int_oe_n), .analog_ready(ready)
  );

  cte_spi_host host (
    .mclk(mclk), .spi_sck(spi_sck), .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic pin(input logic e);
    cmp8("int_pin", {7'h00, e}, {7'h00, int_pin});
  endtask : pin

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, rd_data);
  endtask : wr

  task automatic chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    host.xfer({1'b0, a, 8'h00}, rd_data);
    cmp8($sformatf("reg %h", a), e, rd_data & m);
  endtask : chk

  task automatic smp(input logic dis, input logic [14:0] mag, input int n);
    repeat (n) begin
      @(posedge mclk) begin
        sample       <= '{dis, mag};
        sample_valid <= 1'b1;
      end
      @(posedge mclk) sample_valid <= 1'b0;
    end
  endtask : smp

  task automatic t_regs();
    logic [7:0] e;
    for (int a = 'h31; a <= 'h3A; a++) chk(7'(a), 8'hFF, REG_RESET);
    for (int a = 'h31; a <= 'h3A; a++) begin
      e = (a == 'h38) ? 8'h33 : (a == 'h3A) ? 8'hF0 : 8'hA5;
      wr(7'(a), (a == 'h3A) ? 8'hFF : e);
      chk(7'(a), 8'hFF, e);
    end
    wr(7'h50, 8'hFF);
    chk(7'h50, 8'hFF, 8'h00);
    for (int a = 'h31; a <= 'h3A; a++) wr(7'(a), 8'h00);
  endtask : t_regs

  task automatic t_startup();
    int n;
    int t;
    for (int c = 0; c < 4; c++) begin
      t = BASE << c;
      wr(ADDR_STARTUP, 8'(c << SETTLE_LSB));
      @(posedge mclk) amp_start <= 1'b1;
      @(posedge mclk) amp_start <= 1'b0;
      cyc(2);
      cmp8("ready_drop", 8'h00, {7'h00, ready});
      n = 3;
      while (ready !== 1'b1 && n < 400) begin
        @(posedge mclk);
        n++;
      end
      cmp8("settle_len", 8'h01, {7'h00, n >= t && n <= t + 5});
    end
  endtask : t_startup

  task automatic t_irq();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_IRQ_EN1, ~(8'h01 << i));
      @(posedge mclk) monitor_event <= 8'h01 << i;
      @(posedge mclk) monitor_event <= 8'h00;
      cyc(3);
      pin(1'b1);
      chk(ADDR_FLAG1, 8'hFF, 8'h01 << i);
      wr(ADDR_IRQ_EN1, 8'h01 << i);
      pin(1'b0);
      wr(ADDR_FLAG1, 8'h01 << i);
      cyc(2);
      pin(1'b1);
    end
    wr(ADDR_IRQ_EN1, 8'h00);
  endtask : t_irq

  task automatic t_lim2();
    int n;
    wr(ADDR_LIM2_HI, 8'h01);
    wr(ADDR_LIM2_LO, 8'h00);
    wr(ADDR_IRQ_EN2, 8'h10);
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : 2 << c;
      wr(ADDR_DET_TIMING, 8'(c << LIM2_CNT_LSB));
      // A miss first, so a streak left from the previous code does not carry over.
      smp(1'b0, 15'h0100, 1);
      smp(1'b0, 15'h0101, n - 1);
      // Odd codes break the streak by direction, even codes by an equal magnitude.
      smp(c[0], c[0] ? 15'h7FFF : 15'h0100, 1);
      smp(1'b0, 15'h0101, n - 1);
      chk(ADDR_FLAG2, 8'hFF, 8'h00);
      smp(1'b0, 15'h0101, 1);
      cyc(2);
      pin(1'b0);
      chk(ADDR_FLAG2, 8'hFF, 8'h10);
      wr(ADDR_FLAG2, 8'h10);
      cyc(2);
      pin(1'b1);
    end
  endtask : t_lim2

  task automatic t_lim3();
    wr(ADDR_LIM3_HI, 8'h81);
    wr(ADDR_LIM3_LO, 8'h00);
    wr(ADDR_DET_TIMING, 8'h00);
    wr(ADDR_IRQ_EN2, 8'h40);
    smp(1'b0, 15'h0200, 1);
    chk(ADDR_FLAG2, 8'hFF, 8'h00);
    smp(1'b1, 15'h0101, 1);
    chk(ADDR_FLAG2, 8'hFF, 8'h40);
    wr(ADDR_FLAG2, 8'h40);
    wr(ADDR_IRQ_EN2, 8'h80);
    smp(1'b1, 15'h0100, 1);
    chk(ADDR_FLAG2, 8'hFF, 8'h80);
    pin(1'b0);
    wr(ADDR_FLAG2, 8'h80);
    wr(ADDR_IRQ_EN2, 8'h00);
  endtask : t_lim3

  task automatic t_wake();
    wr(ADDR_WAKE_LVL, 8'h20);
    wr(ADDR_STARTUP, 8'h01);
    wr(ADDR_FLAG3, 8'h07);
    wr(ADDR_IRQ_EN3, 8'h01);
    // Earlier samples left the wake streak saturated; break it before counting.
    smp(1'b0, 15'h0020, 1);
    smp(1'b1, 15'h0021, 3);
    smp(1'b0, 15'h0020, 1);
    smp(1'b0, 15'h0021, 3);
    chk(ADDR_FLAG3, 8'h01, 8'h00);
    smp(1'b0, 15'h0021, 1);
    cyc(2);
    pin(1'b0);
    wr(ADDR_FLAG3, 8'h01);
    wr(ADDR_IRQ_EN3, 8'h00);
  endtask : t_wake

  task automatic t_relax();
    wr(ADDR_RELAX_LVL, 8'h80);
    wr(ADDR_IRQ_EN3, 8'h04);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_DET_TIMING, 8'(c << RELAX_SEL_LSB));
      smp(1'b0, 15'h0081, 1);
      wr(ADDR_FLAG3, 8'h07);
      pin(1'b1);
      smp(1'b1, 15'h0080, 1);
      cyc(30 * MIN * (c + 1) - 10);
      pin(1'b1);
      cyc(20);
      pin(1'b0);
    end
  endtask : t_relax

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_startup();
    t_irq();
    t_lim2();
    t_lim3();
    t_wake();
    t_relax();
    conclude();
  end

endmodule : current_threshold_event_config_tb_top
